//--- inc/fpks_defs.svh
// constants for the front panel key scanner
`ifndef FPKS_DEFS_SVH
`define FPKS_DEFS_SVH
`define FPKS_CLK_HZ 10000000
`define FPKS_ROW_PERIOD_US 100
`define FPKS_ROW_CYCLES ((`FPKS_CLK_HZ / 1000000) * `FPKS_ROW_PERIOD_US)
`define FPKS_ROW_CNT_W 10
`define FPKS_ROWS 4
`define FPKS_COLS 8
`define FPKS_FRAME_BITS 16
`define FPKS_BIT_CNT_W 4
`define FPKS_SPEED_WINDOW_MS 100
`define FPKS_SPEED_CYCLES ((`FPKS_CLK_HZ / 1000) * `FPKS_SPEED_WINDOW_MS)
`define FPKS_SPEED_CNT_W 20
`define FPKS_ROW_IDLE 4'hF
`define FPKS_ROW_RESET 4'hE
`define FPKS_COL_IDLE 8'hFF
`define FPKS_SYNC_W 6
// idle pin levels: switch, phases and chip select high, mosi high, clock low
`define FPKS_SYNC_IDLE 6'h3E
`endif

//--- inc/fpks_pkg.sv
// types for the front panel key scanner
package fpks_pkg;
	typedef enum logic [3:0] {
		FPKS_ROW0 = 4'h1,
		FPKS_ROW1 = 4'h2,
		FPKS_ROW2 = 4'h4,
		FPKS_ROW3 = 4'h8
	} fpks_row_type;
	typedef logic [7:0] fpks_cols_type;
endpackage

//--- inc/fpks_sync_if.sv
// raw pins in and synchronised levels out of the input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface fpks_sync_if;
	logic [5:0] raw;
	logic [5:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface
`default_nettype wire

//--- rtl/fpks_sync.sv
// two-flop synchroniser for the serial and encoder pins
`timescale 1ns/1ps
`default_nettype none
`include "fpks_defs.svh"
module fpks_sync
	import fpks_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	fpks_sync_if.sync pins
);
	logic [`FPKS_SYNC_W-1:0] meta_q;
	logic [`FPKS_SYNC_W-1:0] meta_d;
	logic [`FPKS_SYNC_W-1:0] stable_q;
	logic [`FPKS_SYNC_W-1:0] stable_d;
	always_comb begin
		meta_d = pins.raw;
		stable_d = meta_q;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			// clock bit resets low so the edge finder sees no false rise
			meta_q <= `FPKS_SYNC_IDLE;
			stable_q <= `FPKS_SYNC_IDLE;
		end else begin
			meta_q <= meta_d;
			stable_q <= stable_d;
		end
	end
	assign pins.synced = stable_q;
endmodule
`default_nettype wire

//--- rtl/fpks_top.sv
// front panel key scanner: row walker, column capture, serial slave, encoder
// How it works
// RL1: exactly one of four rows is driven low, the other three high.
// RL2: the low row steps through all four rows and repeats continuously.
// RL3: columns are sampled; a key is the responding column with the low row.
// RL4: host shifts in on MOSI while keypress response shifts out on MISO.
// RL5: serial bus is ignored unless the keypad chip select is low.
// RL6: encoder phases and switch give direction, speed and switch state.
// RL7: a column reading low while its row is low is a pressed key.
`timescale 1ns/1ps
`default_nettype none
`include "fpks_defs.svh"
module fpks_top
	import fpks_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	output logic [3:0] rowDrive,
	input wire logic [7:0] colSense,
	input wire logic spiSck,
	input wire logic spiMosi,
	input wire logic keypadChipSelectN,
	output logic spiMiso,
	output logic spiMisoOe,
	input wire logic encoderPhaseA,
	input wire logic encoderPhaseB,
	input wire logic encoderSwitchN,
	output logic encoderDirUp,
	output logic [7:0] encoderSpeed,
	output logic encoderSwitch,
	output logic [7:0] scanPattern
);
	fpks_sync_if pins();
	fpks_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins(pins)
	);
	logic [7:0] colMeta_q;
	logic [7:0] colSync_q;
	assign pins.raw = {encoderSwitchN, encoderPhaseB, encoderPhaseA,
		keypadChipSelectN, spiMosi, spiSck};
	logic sckS, mosiS, csNS, phaS, phbS, swNS;
	assign {swNS, phbS, phaS, csNS, mosiS, sckS} = pins.synced;

	// ----------------------------------------
	// row walker
	// ----------------------------------------
	fpks_row_type row_q, row_d;
	logic [`FPKS_ROW_CNT_W-1:0] rowCnt_q, rowCnt_d;
	logic [31:0] keyMap_q, keyMap_d;
	logic [31:0] keyLatch_q, keyLatch_d;
	logic [3:0] rowDrive_q, rowDrive_d;
	function automatic logic [1:0] rowIndex(input fpks_row_type r);
		case (r)
			FPKS_ROW0: rowIndex = 2'h0;
			FPKS_ROW1: rowIndex = 2'h1;
			FPKS_ROW2: rowIndex = 2'h2;
			FPKS_ROW3: rowIndex = 2'h3;
			default: rowIndex = 2'h0;
		endcase
	endfunction
	always_comb begin
		row_d = row_q;
		rowCnt_d = rowCnt_q + `FPKS_ROW_CNT_W'(1);
		keyMap_d = keyMap_q;
		keyLatch_d = keyLatch_q;
		if (rowCnt_q == `FPKS_ROW_CNT_W'(`FPKS_ROW_CYCLES - 1)) begin
			rowCnt_d = '0;
			// columns settle for a whole row period before capture
			keyMap_d[rowIndex(row_q)*8 +: 8] = ~colSync_q; // [RL3] [RL7]
			case (row_q) // [RL2]
				FPKS_ROW0: row_d = FPKS_ROW1;
				FPKS_ROW1: row_d = FPKS_ROW2;
				FPKS_ROW2: row_d = FPKS_ROW3;
				FPKS_ROW3: begin
					row_d = FPKS_ROW0;
					keyLatch_d = keyMap_d;
				end
				default: row_d = FPKS_ROW0;
			endcase
		end
		rowDrive_d = ~row_d; // [RL1]
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			row_q <= FPKS_ROW0;
			rowCnt_q <= '0;
			keyMap_q <= '0;
			keyLatch_q <= '0;
			rowDrive_q <= `FPKS_ROW_RESET;
			colMeta_q <= `FPKS_COL_IDLE;
			colSync_q <= `FPKS_COL_IDLE;
		end else begin
			row_q <= row_d;
			rowCnt_q <= rowCnt_d;
			keyMap_q <= keyMap_d;
			keyLatch_q <= keyLatch_d;
			rowDrive_q <= rowDrive_d;
			colMeta_q <= colSense;
			colSync_q <= colMeta_q;
		end
	end
	assign rowDrive = rowDrive_q;

	// ----------------------------------------
	// serial slave, mode 0, msb first
	// ----------------------------------------
	logic sckPrev_q;
	logic [`FPKS_BIT_CNT_W-1:0] bitCnt_q, bitCnt_d;
	logic [15:0] shOut_q, shOut_d;
	logic [7:0] shIn_q, shIn_d;
	logic [7:0] pattern_q, pattern_d;
	logic miso_q, miso_d, misoOe_q, misoOe_d;
	logic csPrev_q;
	wire sckRise = sckS & ~sckPrev_q;
	wire sckFall = ~sckS & sckPrev_q;
	wire csFall = ~csNS & csPrev_q;
	// response: selected row's columns, frame picks row from the pattern's low bits
	logic [7:0] respCols;
	always_comb begin
		respCols = keyLatch_q[pattern_q[1:0]*8 +: 8];
	end
	always_comb begin
		bitCnt_d = bitCnt_q;
		shOut_d = shOut_q;
		shIn_d = shIn_q;
		pattern_d = pattern_q;
		miso_d = miso_q;
		misoOe_d = ~csNS; // [RL5]
		if (csNS) begin // [RL5]
			bitCnt_d = '0;
			miso_d = 1'b0;
		end else if (csFall) begin
			shOut_d = {respCols, row_q, 4'h0};
			miso_d = respCols[7];
			shOut_d = {shOut_d[14:0], 1'b0};
			bitCnt_d = '0;
		end else begin
			if (sckRise) begin // [RL4]
				shIn_d = {shIn_q[6:0], mosiS};
				bitCnt_d = bitCnt_q + `FPKS_BIT_CNT_W'(1);
				if (bitCnt_q == `FPKS_BIT_CNT_W'(7))
					pattern_d = {shIn_q[6:0], mosiS};
			end
			if (sckFall) begin // [RL4]
				miso_d = shOut_q[15];
				shOut_d = {shOut_q[14:0], 1'b0};
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sckPrev_q <= 1'b0;
			csPrev_q <= 1'b1;
			bitCnt_q <= '0;
			shOut_q <= '0;
			shIn_q <= '0;
			pattern_q <= '0;
			miso_q <= 1'b0;
			misoOe_q <= 1'b0;
		end else begin
			sckPrev_q <= sckS;
			csPrev_q <= csNS;
			bitCnt_q <= bitCnt_d;
			shOut_q <= shOut_d;
			shIn_q <= shIn_d;
			pattern_q <= pattern_d;
			miso_q <= miso_d;
			misoOe_q <= misoOe_d;
		end
	end
	assign spiMiso = miso_q;
	assign spiMisoOe = misoOe_q;
	assign scanPattern = pattern_q;

	// ----------------------------------------
	// quadrature decoder
	// ----------------------------------------
	logic [1:0] phPrev_q;
	logic dir_q, dir_d, sw_q, sw_d;
	logic [7:0] steps_q, steps_d, speed_q, speed_d;
	logic [`FPKS_SPEED_CNT_W-1:0] winCnt_q, winCnt_d;
	logic [1:0] phNow;
	logic stepFwd, stepRev;
	always_comb begin
		phNow = {phaS, phbS};
		// gray order 00-01-11-10 is forward; a double jump is dropped as noise
		stepFwd = (phNow != phPrev_q) && (phNow == {phPrev_q[0], ~phPrev_q[1]});
		stepRev = (phNow != phPrev_q) && (phNow == {~phPrev_q[0], phPrev_q[1]});
		dir_d = dir_q;
		steps_d = steps_q;
		speed_d = speed_q;
		winCnt_d = winCnt_q + `FPKS_SPEED_CNT_W'(1);
		if (stepFwd)
			dir_d = 1'b1; // [RL6]
		else if (stepRev)
			dir_d = 1'b0; // [RL6]
		if ((stepFwd || stepRev) && steps_q != 8'hFF)
			steps_d = steps_q + 8'h01;
		if (winCnt_q == `FPKS_SPEED_CNT_W'(`FPKS_SPEED_CYCLES - 1)) begin
			winCnt_d = '0;
			speed_d = steps_d; // [RL6]
			steps_d = '0;
		end
		sw_d = ~swNS; // [RL6]
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			phPrev_q <= 2'h3;
			dir_q <= 1'b0;
			sw_q <= 1'b0;
			steps_q <= '0;
			speed_q <= '0;
			winCnt_q <= '0;
		end else begin
			phPrev_q <= phNow;
			dir_q <= dir_d;
			sw_q <= sw_d;
			steps_q <= steps_d;
			speed_q <= speed_d;
			winCnt_q <= winCnt_d;
		end
	end
	assign encoderDirUp = dir_q;
	assign encoderSpeed = speed_q;
	assign encoderSwitch = sw_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_one_low;
		@(posedge clk) disable iff (rst) $countones(rowDrive_q) == 3;
	endproperty
	a_one_low: assert property (p_one_low) else $error("not one row low"); // [RL1]
	property p_row_step;
		@(posedge clk) disable iff (rst)
			(rowCnt_q == `FPKS_ROW_CNT_W'(`FPKS_ROW_CYCLES - 1))
			|=> (row_q != $past(row_q));
	endproperty
	a_row_step: assert property (p_row_step) else $error("row did not step"); // [RL2]
	property p_row_hold;
		@(posedge clk) disable iff (rst)
			(rowCnt_q != `FPKS_ROW_CNT_W'(`FPKS_ROW_CYCLES - 1)) |=> $stable(row_q);
	endproperty
	a_row_hold: assert property (p_row_hold) else $error("row moved early"); // [RL2]
	property p_key_capture;
		@(posedge clk) disable iff (rst)
			(rowCnt_q == `FPKS_ROW_CNT_W'(`FPKS_ROW_CYCLES - 1)) && row_q == FPKS_ROW0
			|=> keyMap_q[7:0] == ~$past(colSync_q);
	endproperty
	a_key_capture: assert property (p_key_capture) else $error("bad capture"); // [RL3] [RL7]
	sequence s_cs_high;
		csNS [*2];
	endsequence
	property p_cs_ignore;
		@(posedge clk) disable iff (rst) s_cs_high |-> !misoOe_q && bitCnt_q == '0;
	endproperty
	a_cs_ignore: assert property (p_cs_ignore) else $error("active while deselected"); // [RL5]
	property p_shift_in;
		@(posedge clk) disable iff (rst)
			(!csNS && !csFall && sckRise) |=> shIn_q[0] == $past(mosiS);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("mosi not shifted"); // [RL4]
	property p_shift_out;
		@(posedge clk) disable iff (rst)
			(!csNS && !csFall && sckFall) |=> miso_q == $past(shOut_q[15]);
	endproperty
	a_shift_out: assert property (p_shift_out) else $error("miso wrong"); // [RL4]
	property p_dir_fwd;
		@(posedge clk) disable iff (rst) stepFwd |=> encoderDirUp;
	endproperty
	a_dir_fwd: assert property (p_dir_fwd) else $error("direction wrong"); // [RL6]
	property p_switch;
		@(posedge clk) disable iff (rst) ##1 encoderSwitch == !$past(swNS);
	endproperty
	a_switch: assert property (p_switch) else $error("switch state wrong"); // [RL6]
endmodule
`default_nettype wire

//--- testbench/fpks_host_model.sv
// host serial master model for the keypad link, mode 0
`timescale 1ns/1ps
`default_nettype none
module fpks_host_model (
	output logic sck,
	output logic mosi,
	output logic csN,
	input wire logic miso
);
	localparam int HalfNs = 400;
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		csN = 1'b1;
	end
	// frames only run with the chip select low
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		csN = 1'b0;
		#(2 * HalfNs);
		for (int i = 15; i >= 0; i--) begin
			mosi = tx[i]; // msb first on the host data line
			#(HalfNs) sck = 1'b1;
			rx[i] = miso; // response taken in during the same frame
			#(HalfNs) sck = 1'b0;
		end
		#(2 * HalfNs) csN = 1'b1;
		// a released line must not look like it still holds data
		mosi = ~mosi;
		// select stays high long enough for the scanner to see a fresh frame start
		#(2 * HalfNs);
	endtask
	// faulty host: clocks and data with no chip select
	task automatic stray(input int n);
		repeat (n) begin
			mosi = ~mosi;
			#(HalfNs) sck = 1'b1;
			#(HalfNs) sck = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_front_panel_key_scanner.sv
// self-checking bench for the front panel key scanner
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_key_scanner;
	import fpks_pkg::*;
	logic clk, rst, spiSck, spiMosi, csN, spiMiso, spiMisoOe, misoLine, misoLast;
	logic encA, encB, encSwN, encoderDirUp, encoderSwitch, keyOn;
	logic [1:0] keyRow, gray [4];
	logic [3:0] rowDrive, prev;
	logic [7:0] colSense, encoderSpeed, scanPattern, keyCol;
	logic [7:0] tab [5][4];
	logic [15:0] rx;
	int numErrors, nChecks, n;
	fpks_top u_dut (.clk(clk), .rst(rst), .rowDrive(rowDrive), .colSense(colSense),
		.spiSck(spiSck), .spiMosi(spiMosi), .keypadChipSelectN(csN), .spiMiso(spiMiso),
		.spiMisoOe(spiMisoOe), .encoderPhaseA(encA), .encoderPhaseB(encB),
		.encoderSwitchN(encSwN), .encoderDirUp(encoderDirUp), .encoderSpeed(encoderSpeed),
		.encoderSwitch(encoderSwitch), .scanPattern(scanPattern));
	fpks_host_model u_host (.sck(spiSck), .mosi(spiMosi), .csN(csN), .miso(misoLine));
	// keypad: the pressed column reads low only while its row is driven low
	assign colSense = (keyOn && rowDrive[keyRow] == 1'b0) ? ~keyCol : 8'hFF;
	assign misoLine = spiMisoOe ? spiMiso : ~misoLast;
	always @(posedge clk) begin
		if (rst) misoLast <= 1'b0;
		else if (spiMisoOe) misoLast <= spiMiso;
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		nChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(negedge clk) if (!rst) chk(16'($countones(rowDrive)), 16'h3, "one row low");
	initial begin
		repeat (90000) @(posedge clk);
		numErrors++;
		results;
	end
	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial begin
		// pattern, key row, key column, expected response columns
		tab = '{'{8'hA4, 8'h0, 8'h01, 8'h01}, '{8'h3D, 8'h1, 8'h80, 8'h80},
			'{8'hC2, 8'h2, 8'h08, 8'h08}, '{8'h5B, 8'h3, 8'h20, 8'h20},
			'{8'h01, 8'h2, 8'h10, 8'h00}};
		gray = '{2'b00, 2'b01, 2'b11, 2'b10};
		{rst, encA, encB, encSwN, keyOn, keyRow, keyCol} = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00};
		repeat (20) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(rowDrive, 4'hE, "row after reset");
		chk({spiMisoOe, encoderSpeed, scanPattern}, 17'h0, "reset outputs");
		for (int k = 1; k <= 8; k++) begin
			n = 0;
			prev = rowDrive;
			while (rowDrive === prev && n < 1100) begin
				@(negedge clk);
				n++;
			end
			chk(rowDrive, 4'hF ^ (4'h1 << (k % 4)), "row order");
			if (k > 1) chk(16'(n), 16'd1000, "row hold");
		end
		$display("row walk done");
		for (int i = 0; i < 5; i++) begin
			{keyOn, keyRow, keyCol} = {1'b1, tab[i][1][1:0], tab[i][2]};
			repeat (8000) @(negedge clk);
			u_host.xfer({tab[i][0], 8'h00}, rx);
			u_host.xfer({tab[i][0], 8'h00}, rx);
			chk(scanPattern, tab[i][0], "pattern");
			chk(rx[15:8], tab[i][3], "key columns");
			$display("table row %0d done", i);
		end
		u_host.stray(12);
		repeat (10) @(negedge clk);
		chk({spiMisoOe, scanPattern}, {1'b0, tab[4][0]}, "deselected bus");
		$display("deselect test done");
		// upward steps first, then the same path backwards
		for (int s = 1; s <= 8; s++) begin
			{encA, encB} = (s <= 4) ? gray[s % 4] : gray[8 - s];
			repeat (6) @(negedge clk);
			chk(encoderDirUp, s <= 4, "direction");
		end
		encSwN = 1'b0;
		repeat (5) @(negedge clk);
		chk(encoderSwitch, 1'b1, "switch pressed");
		encSwN = 1'b1;
		repeat (5) @(negedge clk);
		chk(encoderSwitch, 1'b0, "switch released");
		$display("encoder test done");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk({rowDrive, scanPattern}, 12'hE00, "mid-run reset");
		rst = 1'b0;
		$display("reset test done");
		results;
	end
endmodule
`default_nettype wire
